// ---- verilog/pswm_core.sv ----
// Purpose: Status word, control registers 0 and 2, masking and interruption take.
// Assumes: Avalon-MM slave, one wait cycle per access; microcode inputs are synchronous.
// Notes: Takes happen only on instr_boundary while low storage is idle.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
module pswm_core import pswm_pkg::*; #(
  parameter int N_CHAN = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic instr_boundary,
  input wire logic ssm_attempt,
  input wire logic [7:0] ssm_mask,
  input wire logic prog_req,
  input wire logic [15:0] prog_code,
  input wire logic [31:0] exc_addr,
  input wire logic svc_req,
  input wire logic [15:0] svc_code,
  input wire logic [1:0] ilc,
  input wire logic [N_SUB-1:0] ext_src,
  input wire logic per_event,
  input wire logic [31:0] per_data,
  input wire logic io_req,
  input wire logic [4:0] io_chan,
  input wire logic [15:0] io_dev,
  output logic ssm_done,
  output logic take,
  output pswm_cls_t take_cls,
  output logic ec_mode,
  output logic dat_on,
  output logic ls_we,
  output logic [8:0] ls_addr,
  output logic [31:0] ls_data
);
  initial if (N_CHAN < 1 || N_CHAN > 32) $error("pswm_core: N_CHAN out of range");

  // ==========================================================
  // Bus slave
  // One wait cycle per access; ack drops for a cycle between accesses
  logic ack_ff;
  logic [31:0] rd_ff;
  logic acc;
  logic wr;
  logic [31:0] bm;
  assign waitrequest = (read | write) & ~ack_ff;
  assign acc = (read | write) & ack_ff;
  assign wr = acc & write;
  assign readdata = rd_ff;
  assign bm = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};

  logic [31:0] psw_ff;
  logic [31:0] cr0_ff;
  logic [31:0] cr2_ff;
  logic [N_EV-1:0] sts_ff;
  logic [N_EV-1:0] msk_ff;
  logic eam_ff;
  logic [N_SUB-1:0] pend;
  logic [N_SUB-1:0] ext_rdy;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (read | write) & ~ack_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ff <= 32'h0000_0000;
    end else if (read && !ack_ff) begin
      // Captured in the wait cycle, stands through the ack cycle
      case (address)
        A_PSW: rd_ff <= psw_ff;
        A_CR0: rd_ff <= cr0_ff;
        A_CR2: rd_ff <= cr2_ff;
        A_STS: rd_ff <= 32'(sts_ff);
        A_MSK: rd_ff <= 32'(msk_ff);
        A_MODE: rd_ff <= {31'h0000_0000, eam_ff};
        A_PEND: rd_ff <= 32'(pend);
        default: rd_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Status word
  logic cr_wr;
  logic cr_refused;
  logic [31:0] psw_wv;
  logic spec_ev;
  logic ssm_ok;
  logic ssm_trap;
  assign psw_wv = (psw_ff & ~bm) | (writedata & bm);
  assign spec_ev = wr && address == A_PSW && eam_ff && psw_wv[P_DAT];
  assign cr_wr = wr && (address == A_CR0 || address == A_CR2);
  assign cr_refused = cr_wr && psw_ff[P_PROB];
  assign ssm_trap = ssm_attempt && cr0_ff[C0_SSM];
  assign ssm_ok = ssm_attempt && !cr0_ff[C0_SSM];

  // Bit 12 is a format selector only; no character-set mode exists
  assign ec_mode = psw_ff[P_EC];
  assign dat_on = psw_ff[P_DAT] & ec_mode;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psw_ff <= RST_PSW;
    end else if (wr && address == A_PSW) begin
      // Translation bit forced off in entry-assist mode
      psw_ff <= eam_ff ? (psw_wv & ~(32'h1 << P_DAT)) : psw_wv;
    end else if (ssm_ok) begin
      psw_ff[31:24] <= ssm_mask;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ssm_done <= 1'b0;
    end else begin
      // Executed mask update reported one cycle later
      ssm_done <= ssm_ok;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cr0_ff <= RST_CR;
      cr2_ff <= RST_CR;
    end else if (cr_wr && !cr_refused) begin
      // Problem state refuses the load; the refusal is flagged in status
      if (address == A_CR0) begin
        cr0_ff <= (cr0_ff & ~bm) | (writedata & bm);
      end else begin
        cr2_ff <= (cr2_ff & ~bm) | (writedata & bm);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msk_ff <= '0;
      eam_ff <= 1'b0;
    end else if (wr && address == A_MSK) begin
      msk_ff <= writedata[N_EV-1:0];
    end else if (wr && address == A_MODE) begin
      eam_ff <= writedata[0];
    end
  end

  // ==========================================================
  // Masking
  logic io_en;
  logic per_en;
  logic ext_any;
  logic take_ext;
  // Pending externals wait for both summary and subclass masks
  pswm_ext_gate #(
    .N(N_SUB)
  ) u_ext (
    .clk(clk),
    .rst(rst),
    .src(ext_src),
    .summary_en(psw_ff[P_EXT]),
    .sub_en(cr0_ff[C0_SUB_LO +: N_SUB]),
    .take(take_ext),
    .pend(pend),
    .ready(ext_rdy)
  );
  assign ext_any = |ext_rdy;

  always_comb begin
    io_en = 1'b0;
    if (ec_mode) begin
      // Summary mask and per-channel mask in control register 2
      io_en = psw_ff[P_IO] && io_chan < N_CHAN && cr2_ff[31 - io_chan];
    end else if (io_chan < 5'd6) begin
      // Basic format: channels 0-5 own a mask bit, the rest share bit 6
      io_en = psw_ff[31 - io_chan];
    end else begin
      io_en = psw_ff[P_IO];
    end
  end
  assign per_en = ec_mode && psw_ff[P_PER] && per_event;

  // ==========================================================
  // Interruption take
  logic ls_busy;
  logic boundary_ok;
  logic take_pgm;
  logic take_svc;
  logic take_io;
  logic take_any;
  pswm_cls_t cls;
  logic [15:0] code;
  logic [31:0] aux;
  logic aux_vld;
  // Takes only at a boundary, and never while an aux word is still pending
  assign boundary_ok = instr_boundary && !ls_busy;
  assign take_pgm = boundary_ok && (ssm_trap || prog_req);
  assign take_svc = boundary_ok && !take_pgm && svc_req;
  assign take_ext = boundary_ok && !take_pgm && !svc_req && ext_any;
  assign take_io = boundary_ok && !take_pgm && !svc_req && !ext_any && io_req && io_en;
  // Fixed priority: program, supervisor call, external, then I/O
  assign take_any = take_pgm | take_svc | take_ext | take_io;

  always_comb begin
    cls = CLS_IO;
    code = io_dev;
    aux = 32'h0000_0000;
    aux_vld = 1'b0;
    if (take_pgm) begin
      cls = CLS_PGM;
      code = ssm_trap ? PGM_SSM_CODE : prog_code;
      aux = exc_addr;
      aux_vld = !ssm_trap;
    end else if (take_svc) begin
      cls = CLS_SVC;
      code = svc_code;
    end else if (take_ext) begin
      cls = CLS_EXT;
      code = 16'(ext_rdy & ~(ext_rdy - 1'b1));
      aux = per_data;
      aux_vld = per_en;
    end else begin
      cls = CLS_IO;
      code = io_dev;
      aux = per_data;
      aux_vld = per_en;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      take <= 1'b0;
      take_cls <= CLS_EXT;
    end else begin
      take <= take_any;
      take_cls <= cls;
    end
  end

  pswm_lowstore u_ls (
    .clk(clk),
    .rst(rst),
    .start(take_any),
    .ec(ec_mode),
    .cls(cls),
    .code(code),
    .ilc(ilc),
    .aux(aux),
    .aux_vld(aux_vld),
    .busy(ls_busy),
    .ls_we(ls_we),
    .ls_addr(ls_addr),
    .ls_data(ls_data)
  );

  // ==========================================================
  // Sticky events and interrupt
  // Every take or refusal latches a sticky status bit
  logic [N_EV-1:0] ev;
  always_comb begin
    ev = '0;
    ev[E_EXT] = take_ext;
    ev[E_IO] = take_io;
    ev[E_SSM] = take_pgm && ssm_trap;
    ev[E_PGM] = take_pgm;
    ev[E_SVC] = take_svc;
    ev[E_PRIV] = cr_refused;
    ev[E_SPEC] = spec_ev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sts_ff <= '0;
    end else if (wr && address == A_STS) begin
      // Set wins over a write-one-to-clear in the same cycle
      sts_ff <= (sts_ff & ~writedata[N_EV-1:0]) | ev;
    end else begin
      sts_ff <= sts_ff | ev;
    end
  end
  assign irq = |(sts_ff & msk_ff);

  // ==========================================================
  // Checks: masking and take
  ext_off_a: assert property (@(posedge clk) disable iff (rst)
    !psw_ff[P_EXT] |-> !take_ext) else $error("external taken while masked");
  ext_sub_a: assert property (@(posedge clk) disable iff (rst)
    take_ext |-> |(pend & cr0_ff[C0_SUB_LO +: N_SUB])) else $error("subclass mask ignored");
  pend_hold_a: assert property (@(posedge clk) disable iff (rst)
    !take_ext |=> (pend & $past(pend)) == $past(pend))
    else $error("pending external dropped");
  ssm_trap_a: assert property (@(posedge clk) disable iff (rst)
    ssm_attempt && cr0_ff[C0_SSM] |=> !ssm_done && $stable(psw_ff[31:24]))
    else $error("trapped mask update executed");
  ssm_take_a: assert property (@(posedge clk) disable iff (rst)
    take_pgm && ssm_trap |=> take && take_cls == CLS_PGM && sts_ff[E_SSM])
    else $error("mask update trap not taken");
  ssm_exec_a: assert property (@(posedge clk) disable iff (rst)
    ssm_ok && !(wr && address == A_PSW) |=> ssm_done && psw_ff[31:24] == $past(ssm_mask))
    else $error("mask update not executed");
  take_bound_a: assert property (@(posedge clk) disable iff (rst)
    take |-> $past(instr_boundary)) else $error("take off a boundary");
  busy_block_a: assert property (@(posedge clk) disable iff (rst)
    ls_busy |=> !take)
    else $error("take while low storage busy");
  io_chan_a: assert property (@(posedge clk) disable iff (rst)
    take_io && ec_mode |-> cr2_ff[31 - io_chan] && psw_ff[P_IO]) else $error("channel mask ignored");
  dat_zero_a: assert property (@(posedge clk) disable iff (rst)
    eam_ff && wr && address == A_PSW |=> !psw_ff[P_DAT]) else $error("translation set in entry assist");
  cr_priv_a: assert property (@(posedge clk) disable iff (rst)
    cr_refused |=> $stable(cr0_ff) && $stable(cr2_ff) && sts_ff[E_PRIV]) else $error("control register loaded");
  sts_set_a: assert property (@(posedge clk) disable iff (rst)
    ev[E_EXT] |=> sts_ff[E_EXT]) else $error("event lost");

  // ==========================================================
  // Checks: low storage
  bc_code_a: assert property (@(posedge clk) disable iff (rst)
    take_svc && !ec_mode |=> ls_we && ls_addr == LS_SVC_OLD)
    else $error("old layout not kept");
  ec_code_a: assert property (@(posedge clk) disable iff (rst)
    take_svc && ec_mode |=> ls_we && ls_addr == LS_SVC_CODE) else $error("code not in low storage");
  ext_code_a: assert property (@(posedge clk) disable iff (rst)
    take_ext && ec_mode |=> ls_we && ls_addr == LS_EXT_CODE)
    else $error("external code not in low storage");
  io_addr_a: assert property (@(posedge clk) disable iff (rst)
    take_io && ec_mode |=> ls_we && ls_addr == LS_IO_ADDR)
    else $error("device address not in low storage");
  per_store_a: assert property (@(posedge clk) disable iff (rst)
    take_io && ec_mode && psw_ff[P_PER] && per_event |=> ##1 ls_we && ls_addr == LS_PER_DATA)
    else $error("event recording data not stored");
  exc_addr_a: assert property (@(posedge clk) disable iff (rst)
    take_pgm && !ssm_trap && !ec_mode |=> ##1 ls_we && ls_addr == LS_EXC_ADDR)
    else $error("access address not stored");
endmodule : pswm_core

// ---- verilog/pswm_pkg.sv ----
// Purpose: Constants and types for the status word mode and masking block.
// Assumes: Status word bit n (bit 0 = MSB) sits at index 31-n of a 32-bit word.
// Notes: Function
// Function
// - Status word bit 12 selects basic or extended control format only.
// - No alternate character-set mode exists; conversion is software's job.
// - Basic format keeps the earlier low-storage layout of locations 0-127.
// - Control register 0 holds five external subclass mask bits.
// - External mask clear: no external interruption of any type is taken.
// - External mask set: a type is taken only with its subclass mask set.
// - Trap bit set: set-system-mask causes a program interruption, not executed.
// - Trap bit clear: set-system-mask executes normally.
// - Interruptions are taken only at instruction boundaries, never imprecise.
// - Extended format takes channel masks from control register 2.
// - Extended format stores length and interruption codes above address 127.
// - Extended status word has summary masks for I/O, external, event recording.
// - Status word bit 5 enables translation; it must be zero in entry assist; only status word bus writes force it off here, set-system-mask can set it.
// - Extended format also stores event data, I/O address, translation address; no translation address is stored here.
// - Low-storage locations 252 to 255 are never written.
// - Basic format also stores the access exception address.
// - Control registers are 32 bits wide.
// - Control registers are loaded only in supervisor state.
package pswm_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [4:0] A_PSW = 5'h00;
  localparam logic [4:0] A_CR0 = 5'h04;
  localparam logic [4:0] A_CR2 = 5'h08;
  localparam logic [4:0] A_STS = 5'h0C;
  localparam logic [4:0] A_MSK = 5'h10;
  localparam logic [4:0] A_MODE = 5'h14;
  localparam logic [4:0] A_PEND = 5'h18;
  localparam logic [31:0] RST_PSW = 32'h0000_0000;
  localparam logic [31:0] RST_CR = 32'h0000_0000;
  // ==========================================================
  // Status word bit indices
  localparam int P_EC = 31 - 12;
  localparam int P_DAT = 31 - 5;
  localparam int P_PER = 31 - 1;
  localparam int P_IO = 31 - 6;
  localparam int P_EXT = 31 - 7;
  localparam int P_PROB = 31 - 15;
  // ==========================================================
  // Control register 0 fields
  localparam int C0_SSM = 31 - 1;
  localparam int C0_SUB_LO = 31 - 26;
  localparam int N_SUB = 5;
  // ==========================================================
  // Status event bits
  localparam int E_EXT = 0;
  localparam int E_IO = 1;
  localparam int E_SSM = 2;
  localparam int E_PGM = 3;
  localparam int E_SVC = 4;
  localparam int E_PRIV = 5;
  localparam int E_SPEC = 6;
  localparam int N_EV = 7;
  // ==========================================================
  // Low-storage addresses
  localparam logic [8:0] LS_EXT_OLD = 9'h018;
  localparam logic [8:0] LS_SVC_OLD = 9'h020;
  localparam logic [8:0] LS_PGM_OLD = 9'h028;
  localparam logic [8:0] LS_IO_OLD = 9'h038;
  localparam logic [8:0] LS_EXT_CODE = 9'h084;
  localparam logic [8:0] LS_SVC_CODE = 9'h088;
  localparam logic [8:0] LS_PGM_CODE = 9'h08C;
  localparam logic [8:0] LS_EXC_ADDR = 9'h090;
  localparam logic [8:0] LS_PER_DATA = 9'h098;
  localparam logic [8:0] LS_IO_ADDR = 9'h0B8;
  localparam logic [8:0] LS_RSV_LO = 9'h0FC;
  localparam logic [8:0] LS_RSV_HI = 9'h0FF;
  localparam logic [15:0] PGM_SSM_CODE = 16'h0013;
  typedef enum logic [1:0] {CLS_EXT, CLS_SVC, CLS_PGM, CLS_IO} pswm_cls_t;
endpackage : pswm_pkg

// ---- verilog/pswm_ext_gate.sv ----
// Purpose: Holds external requests pending and gates them by both mask levels.
// Assumes: Sources are level or pulse; a pending bit clears only when taken.
// Notes: Set wins over the take clear.
`timescale 1ns/1ns
module pswm_ext_gate import pswm_pkg::*; #(
  parameter int N = N_SUB
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] src,
  input wire logic summary_en,
  input wire logic [N-1:0] sub_en,
  input wire logic take,
  output logic [N-1:0] pend,
  output logic [N-1:0] ready
);
  initial if (N < 1 || N > 8) $error("pswm_ext_gate: N out of range");
  logic [N-1:0] pend_ff;
  logic [N-1:0] pick;
  assign pend = pend_ff;
  assign pick = ready & ~(ready - 1'b1);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_sub
      // Summary and subclass both required
      assign ready[i] = pend_ff[i] & summary_en & sub_en[i];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pend_ff[i] <= 1'b0;
        end else if (src[i]) begin
          pend_ff[i] <= 1'b1;
        end else if (take && pick[i]) begin
          pend_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate
  ext_pending_a: assert property (@(posedge clk) disable iff (rst)
    |src |=> (pend_ff & $past(src)) == $past(src)) else $error("external request lost");
endmodule : pswm_ext_gate

// ---- verilog/pswm_lowstore.sv ----
// Purpose: Writes interruption codes and addresses into fixed low storage.
// Assumes: One word per cycle; start is accepted only while idle.
// Notes: Extended format uses fields above 127; basic uses the old status words.
`timescale 1ns/1ns
module pswm_lowstore import pswm_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic ec,
  input wire pswm_cls_t cls,
  input wire logic [15:0] code,
  input wire logic [1:0] ilc,
  input wire logic [31:0] aux,
  input wire logic aux_vld,
  output logic busy,
  output logic ls_we,
  output logic [8:0] ls_addr,
  output logic [31:0] ls_data
);
  logic [8:0] aux_addr_ff;
  logic [31:0] aux_ff;
  logic aux_pend_ff;
  logic [8:0] code_a;
  logic [8:0] aux_a;
  assign busy = aux_pend_ff;
  always_comb begin
    code_a = LS_EXT_OLD;
    aux_a = LS_EXC_ADDR;
    case (cls)
      CLS_EXT: code_a = ec ? LS_EXT_CODE : LS_EXT_OLD;
      CLS_SVC: code_a = ec ? LS_SVC_CODE : LS_SVC_OLD;
      CLS_PGM: code_a = ec ? LS_PGM_CODE : LS_PGM_OLD;
      CLS_IO: begin
        code_a = ec ? LS_IO_ADDR : LS_IO_OLD;
      end
      default: code_a = LS_EXT_OLD;
    endcase
    if (cls == CLS_PGM) begin
      aux_a = LS_EXC_ADDR;
    end else begin
      aux_a = LS_PER_DATA;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ls_we <= 1'b0;
      ls_addr <= 9'h000;
      ls_data <= 32'h0000_0000;
    end else if (start && !aux_pend_ff) begin
      ls_we <= 1'b1;
      ls_addr <= code_a;
      ls_data <= {14'h0000, ilc, code};
    end else if (aux_pend_ff) begin
      ls_we <= 1'b1;
      ls_addr <= aux_addr_ff;
      ls_data <= aux_ff;
    end else begin
      ls_we <= 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_pend_ff <= 1'b0;
      aux_addr_ff <= 9'h000;
      aux_ff <= 32'h0000_0000;
    end else if (start && !aux_pend_ff) begin
      // Event data only exists in extended format; access address in both
      aux_pend_ff <= aux_vld && (ec || cls == CLS_PGM);
      aux_addr_ff <= aux_a;
      aux_ff <= aux;
    end else begin
      aux_pend_ff <= 1'b0;
    end
  end
  no_reserved_a: assert property (@(posedge clk) disable iff (rst)
    ls_we |-> !(ls_addr >= LS_RSV_LO && ls_addr <= LS_RSV_HI))
    else $error("reserved low storage written");
endmodule : pswm_lowstore

// ---- dv/pswm_tb.sv ----
// Purpose: Self-checking bench for the status word mode and masking core.
// Assumes: Bus answers after one wait cycle; takes land one cycle after a boundary.
// Notes: Expected reads, takes and low-storage writes are queued and checked by a watcher.
`timescale 1ns/1ns
module psw_mode_interrupt_masking_tb_top import pswm_pkg::*; ();
  // ==========================================================
  // Signals
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [4:0] address = 5'h00;
  logic read = 1'h0, write = 1'h0, instr_boundary = 1'h0, ssm_attempt = 1'h0;
  logic prog_req = 1'h0, svc_req = 1'h0, per_event = 1'h0, io_req = 1'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, exc_addr = 32'h0, per_data = 32'h0;
  logic [7:0] ssm_mask = 8'h00;
  logic [15:0] prog_code = 16'h0, svc_code = 16'h0, io_dev = 16'h0;
  logic [1:0] ilc = 2'h0;
  logic [N_SUB-1:0] ext_src = 5'h00;
  logic [4:0] io_chan = 5'h00;
  logic [31:0] readdata, ls_data;
  logic waitrequest, irq, ssm_done, take, ec_mode, dat_on, ls_we;
  pswm_cls_t take_cls;
  logic [8:0] ls_addr;
  logic [63:0] rdq[$];
  logic [3:0] tq[$];
  logic [72:0] lq[$];
  logic [72:0] e;
  logic [31:0] rng = 32'h00016B28;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;

  always #4 clk = ~clk;

  pswm_core uut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .instr_boundary(instr_boundary), .ssm_attempt(ssm_attempt), .ssm_mask(ssm_mask),
    .prog_req(prog_req), .prog_code(prog_code), .exc_addr(exc_addr), .svc_req(svc_req),
    .svc_code(svc_code), .ilc(ilc), .ext_src(ext_src), .per_event(per_event), .per_data(per_data),
    .io_req(io_req), .io_chan(io_chan), .io_dev(io_dev), .ssm_done(ssm_done), .take(take),
    .take_cls(take_cls), .ec_mode(ec_mode), .dat_on(dat_on), .ls_we(ls_we), .ls_addr(ls_addr),
    .ls_data(ls_data));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input logic [72:0] got, input logic [72:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    if (!wr) rdq.push_back({m, d & m});
    @(posedge clk);
    while (waitrequest !== 1'h0) @(posedge clk);
    write <= 1'h0;
    read <= 1'h0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'h1, a, d, 32'h0);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m);
    bus(1'h0, a, d, m);
  endtask : rd

  task automatic bnd(input logic s);
    @(posedge clk);
    instr_boundary <= 1'h1;
    ssm_attempt <= s;
    @(posedge clk);
    instr_boundary <= 1'h0;
    ssm_attempt <= 1'h0;
    repeat (4) @(posedge clk);
  endtask : bnd

  task automatic el(input logic [8:0] a, input logic [31:0] m, input logic [31:0] d);
    lq.push_back({a, m, d & m});
  endtask : el

  // Samples a level away from the launching edge
  task automatic ckn(ref logic s, input logic v);
    @(negedge clk);
    chk(73'(s), 73'(v));
    @(posedge clk);
  endtask : ckn

  // ==========================================================
  // Watcher
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      final_report();
    end
    if (!rst) begin
      if (read && !waitrequest) begin
        if (rdq.size() == 0) chk(73'h1, 73'h0);
        else begin
          e = 73'(rdq.pop_front());
          chk(73'(readdata & e[63:32]), 73'(e[31:0]));
        end
      end
      if (take || ssm_done) begin
        if (tq.size() == 0) chk(73'h1, 73'h0);
        else chk(73'({ssm_done, take, take ? take_cls : CLS_EXT}), 73'(tq.pop_front()));
      end
      if (ls_we) begin
        if (lq.size() == 0) chk(73'h1, 73'h0);
        else begin
          e = lq.pop_front();
          chk({ls_addr, e[63:32], ls_data & e[63:32]}, e);
        end
        chk(73'(ls_addr >= LS_RSV_LO && ls_addr <= LS_RSV_HI), 73'h0);
      end
    end
  end

  // ==========================================================
  // Sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0, 32'hFFFFFFFF);
    rng = xs(rng);
    wr(A_CR2, rng);
    rd(A_CR2, rng, 32'hFFFFFFFF);
    byteenable <= 4'h1;
    wr(A_CR2, 32'h0);
    byteenable <= 4'hF;
    rd(A_CR2, {rng[31:8], 8'h00}, 32'hFFFFFFFF);
    wr(5'h1C, rng);
    rd(5'h1C, 32'h0, 32'hFFFFFFFF);
    svc_code <= 16'h00A5;
    ilc <= 2'h2;
    svc_req <= 1'h1;
    tq.push_back({2'h1, CLS_SVC});
    el(LS_SVC_OLD, 32'h0, 32'h0);
    bnd(1'h0);
    rng = xs(rng);
    exc_addr <= rng;
    prog_code <= 16'h0011;
    svc_req <= 1'h0;
    prog_req <= 1'h1;
    tq.push_back({2'h1, CLS_PGM});
    el(LS_PGM_OLD, 32'h0, 32'h0);
    el(LS_EXC_ADDR, 32'hFFFFFFFF, rng);
    bnd(1'h0);
    prog_req <= 1'h0;
    wr(A_PSW, 32'h1 << P_EC);
    ckn(ec_mode, 1'h1);
    svc_req <= 1'h1;
    tq.push_back({2'h1, CLS_SVC});
    el(LS_SVC_CODE, 32'hFFFFFFFF, 32'h0002_00A5);
    bnd(1'h0);
    svc_req <= 1'h0;
    wr(A_CR0, 32'h1 << (C0_SUB_LO + 2));
    ext_src <= 5'h04;
    @(posedge clk);
    ext_src <= 5'h00;
    bnd(1'h0);
    rd(A_PEND, 32'h4, 32'hFFFFFFFF);
    wr(A_CR0, 32'h0);
    wr(A_PSW, (32'h1 << P_EC) | (32'h1 << P_EXT));
    bnd(1'h0);
    tq.push_back({2'h1, CLS_EXT});
    el(LS_EXT_CODE, 32'hFFFF, 32'h4);
    wr(A_CR0, 32'h1 << (C0_SUB_LO + 2));
    bnd(1'h0);
    rd(A_PEND, 32'h0, 32'hFFFFFFFF);
    rng = xs(rng);
    wr(A_CR2, 32'h0);
    wr(A_PSW, (32'h1 << P_EC) | (32'h1 << P_IO) | (32'h1 << P_PER));
    io_chan <= 5'h03;
    io_dev <= rng[31:16];
    per_data <= rng;
    per_event <= 1'h1;
    io_req <= 1'h1;
    bnd(1'h0);
    wr(A_CR2, 32'hFFFFFFFF);
    tq.push_back({2'h1, CLS_IO});
    el(LS_IO_ADDR, 32'hFFFF, {16'h0, rng[31:16]});
    el(LS_PER_DATA, 32'hFFFFFFFF, rng);
    bnd(1'h0);
    io_req <= 1'h0;
    per_event <= 1'h0;
    wr(A_PSW, (32'h1 << P_EC) | (32'h1 << P_DAT));
    ckn(dat_on, 1'h1);
    wr(A_MODE, 32'h1);
    wr(A_PSW, (32'h1 << P_EC) | (32'h1 << P_DAT));
    ckn(dat_on, 1'h0);
    rd(A_STS, 32'h40, 32'h40);
    wr(A_MODE, 32'h0);
    wr(A_CR0, 32'h1 << C0_SSM);
    ssm_mask <= 8'h03;
    tq.push_back({2'h1, CLS_PGM});
    el(LS_PGM_CODE, 32'hFFFF, {16'h0, PGM_SSM_CODE});
    bnd(1'h1);
    wr(A_CR0, 32'h0);
    tq.push_back(4'h8);
    bnd(1'h1);
    rd(A_PSW, 32'h0300_0000, 32'hFF00_0000);
    wr(A_PSW, 32'h1 << P_PROB);
    wr(A_CR0, 32'hFFFFFFFF);
    rd(A_CR0, 32'h0, 32'hFFFFFFFF);
    rd(A_STS, 32'h20, 32'h20);
    wr(A_PSW, 32'h0);
    wr(A_STS, 32'h7F);
    rd(A_STS, 32'h0, 32'hFFFFFFFF);
    wr(A_MSK, 32'h10);
    ckn(irq, 1'h0);
    svc_req <= 1'h1;
    tq.push_back({2'h1, CLS_SVC});
    el(LS_SVC_OLD, 32'h0, 32'h0);
    bnd(1'h0);
    svc_req <= 1'h0;
    ckn(irq, 1'h1);
    wr(A_MSK, 32'h0);
    ckn(irq, 1'h0);
    wr(A_MSK, 32'h10);
    ckn(irq, 1'h1);
    wr(A_STS, 32'h10);
    ckn(irq, 1'h0);
    repeat (4) @(posedge clk);
    chk(73'(tq.size() + lq.size() + rdq.size()), 73'h0);
    final_report();
  end
endmodule : psw_mode_interrupt_masking_tb_top
